//--- src/mhp_consts.svh
// constants for the host port and power control block
`ifndef MHP_CONSTS_SVH
`define MHP_CONSTS_SVH
`define MHP_SEL_DATA 1'b0
`define MHP_SEL_CTRL 1'b1
`define MHP_CMD_RESET 8'hff
`define MHP_CMD_UART 8'h3f
`define MHP_ACK_BYTE 8'hfe
`define MHP_STAT_OUT_BUSY 6
`define MHP_STAT_IN_EMPTY 7
`define MHP_BAUD_NS 32000
`define MHP_CLK_NS 4
`define MHP_BIT_CYC ((`MHP_BAUD_NS) / (`MHP_CLK_NS))
`define MHP_RUN_DELAY 16
`endif

//--- src/mhp_pkg.sv
// types for the host port and power control block
package mhp_pkg;
   typedef enum logic [2:0] {
      MHP_RX_IDLE = 3'b001,
      MHP_RX_DATA = 3'b010,
      MHP_RX_STOP = 3'b100
   } mhp_rx_e;
   typedef logic [7:0] mhp_byte_t;
endpackage

//--- src/mhp_uart_rx.sv
// serial midi receiver, 8n1
`timescale 1ns/100ps
`include "mhp_consts.svh"
module mhp_uart_rx #(
   parameter int BIT_CYC = `MHP_BIT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic rx_i,
   output mhp_pkg::mhp_byte_t data_o,
   output logic valid_o
);
   import mhp_pkg::*;
   // refuse a bit period too short to find the bit middle
   if (BIT_CYC < 4) begin : g_bad_bit
      $error("bit period too short");
   end
   mhp_rx_e state;
   logic [31:0] cnt;
   logic [2:0] bit_idx;
   mhp_byte_t shift;
   wire cnt_done = (cnt == 32'd0);
   // start bit taken on its falling edge, first data bit sampled mid-bit, data bits one period apart
   always_ff @(posedge sys_clk_i) begin
      valid_o <= 1'b0;
      if (srst_i) begin
         state <= MHP_RX_IDLE;
         cnt <= 32'd0;
         bit_idx <= 3'd0;
         shift <= 8'h00;
         data_o <= 8'h00;
      end else begin
         unique case (state)
            MHP_RX_IDLE: begin
               if (!rx_i) begin
                  state <= MHP_RX_DATA;
                  cnt <= 32'(BIT_CYC + BIT_CYC / 2 - 1);
                  bit_idx <= 3'd0;
               end
            end
            MHP_RX_DATA: begin
               if (cnt_done) begin
                  shift <= {rx_i, shift[7:1]};
                  cnt <= 32'(BIT_CYC - 1);
                  bit_idx <= bit_idx + 3'd1;
                  if (bit_idx == 3'd7) state <= MHP_RX_STOP;
               end else cnt <= cnt - 32'd1;
            end
            MHP_RX_STOP: begin
               if (cnt_done) begin
                  // a broken stop bit drops the byte
                  if (rx_i) begin
                     data_o <= shift;
                     valid_o <= 1'b1;
                  end
                  state <= MHP_RX_IDLE;
               end else cnt <= cnt - 32'd1;
            end
         endcase
      end
   end
endmodule

//--- src/mhp_host_port.sv
// parallel host port with uart pass-through and power control
`timescale 1ns/100ps
`include "mhp_consts.svh"
// Function
// - with register select low, host reads and writes reach the data register.
// - with register select high, reads return status and writes load control.
// - the 8-bit data bus is driven or sampled only under chip select and the strobes.
// - after power-up or port reset, midi input feeds the synthesizer.
// - in uart mode received midi bytes go to the host data register instead.
// - while power-down is low every output but the bus enable (held high) is forced to 0.
// - while power-down is low clock generation is halted.
// - reset is active low and holds the port registers and receiver while low, but not the output stage.
// - the running output is high only while the synthesizer operates.
// - a buffered crystal clock copy is given out as converter master clock.
// - a read happens with chip select and read low; read rising edge acknowledges.
// - a write is captured on the write strobe rising edge, steered by select.
// - interrupt rises when a uart-mode midi byte or a command acknowledge is ready and clears when it is read.
// - the port answers only while chip select is low.
module mhp_host_port #(
   parameter int BIT_CYC = `MHP_BIT_CYC,
   parameter int RUN_DELAY = `MHP_RUN_DELAY
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic reset_n_i,
   input wire logic power_down_n_i,
   input wire logic chip_select_n_i,
   input wire logic read_n_i,
   input wire logic write_n_i,
   input wire logic register_select_i,
   input wire mhp_pkg::mhp_byte_t host_data_bus_i,
   output mhp_pkg::mhp_byte_t host_data_bus_o,
   output logic host_data_bus_oe_n_o,
   input wire logic midi_in_i,
   input wire logic crystal_clk_i,
   output logic irq_o,
   output logic run_o,
   output logic buffered_crystal_clock_out_o,
   output logic clock_gen_enable_o,
   output logic synth_midi_o
);
   import mhp_pkg::*;

   // refuse parameters the counters cannot serve: run_cnt is eight bits wide
   if (RUN_DELAY < 1 || RUN_DELAY > 255) begin : g_bad_run
      $error("run delay out of range");
   end
   // the receiver needs a few cycles a bit to find the middle of each bit
   if (BIT_CYC < 4) begin : g_bad_bit
      $error("bit period too short");
   end

   // strobe end: a low level seen under chip select, high again now
   function automatic logic strobe_end(input logic active_q, input logic now_n, input logic was_n);
      return active_q && now_n && !was_n;
   endfunction

   // register select decode, shared by the read and write paths
   function automatic logic sel_is_data(input logic sel);
      return sel == `MHP_SEL_DATA;
   endfunction

   // command decode, valid only on a control write
   function automatic logic cmd_hit(input logic ctrl_wr, input mhp_byte_t d, input mhp_byte_t code);
      return ctrl_wr && d == code;
   endfunction

   // status byte: only the empty flag can be set, the send side never stalls
   function automatic mhp_byte_t status_byte(input logic has_byte);
      mhp_byte_t s;
      s = 8'h00;
      s[`MHP_STAT_IN_EMPTY] = !has_byte;
      s[`MHP_STAT_OUT_BUSY] = 1'b0;
      return s;
   endfunction

   // every pin passes two flops, so a strobe edge is acted on two cycles after it
   // arrives and the registered outputs answer one cycle later; a host that holds a
   // strobe for less than one cycle low and one high may not be seen at all,
   // which is the price of keeping every pin out of the logic until it is settled

   // two-flop synchronisers for every pin input
   logic [6:0] sync1;
   logic [6:0] sync2;
   mhp_byte_t data_s1;
   mhp_byte_t data_s2;
   logic xtal_s1;
   logic xtal_s2;
   always_ff @(posedge sys_clk_i) begin
      sync1 <= {reset_n_i, power_down_n_i, chip_select_n_i, read_n_i, write_n_i, register_select_i, midi_in_i};
      sync2 <= sync1;
      data_s1 <= host_data_bus_i;
      data_s2 <= data_s1;
      xtal_s1 <= crystal_clk_i;
      xtal_s2 <= xtal_s1;
   end
   wire rst_n_s = sync2[6];
   wire power_down_n_n_s = sync2[5];
   wire cs_n_s = sync2[4];
   wire rd_n_s = sync2[3];
   wire wr_n_s = sync2[2];
   wire sel_s = sync2[1];
   wire midi_s = sync2[0];

   // previous strobe levels for edge detection, on synchronised copies only
   logic rd_n_q;
   logic wr_n_q;
   logic cs_rd_q;
   logic cs_wr_q;
   logic sel_q;
   always_ff @(posedge sys_clk_i) begin
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
      cs_rd_q <= !cs_n_s && !rd_n_s;
      cs_wr_q <= !cs_n_s && !wr_n_s;
      sel_q <= sel_s;
   end

   // power-down holds the port as well, so the reset pulse that must follow finds it clean
   // reset pin low
   wire hold_rst = srst_i || !rst_n_s || !power_down_n_n_s;

   // decoded strobe ends, each true for exactly one cycle
   // chip select gates cycles
   wire rd_ack = strobe_end(cs_rd_q, rd_n_s, rd_n_q);
   wire wr_cap = strobe_end(cs_wr_q, wr_n_s, wr_n_q);
   wire wr_data = wr_cap && sel_is_data(sel_q);
   wire wr_ctrl = wr_cap && sel_q == `MHP_SEL_CTRL;
   wire rd_data = rd_ack && sel_is_data(sel_q);

   // unknown control bytes change no mode; they only load the acknowledge byte
   wire cmd_reset = cmd_hit(wr_ctrl, data_s2, `MHP_CMD_RESET);
   wire cmd_uart = cmd_hit(wr_ctrl, data_s2, `MHP_CMD_UART);

   // the receiver runs in both modes; its bytes are kept only in uart mode
   mhp_byte_t rx_byte;
   logic rx_valid;
   mhp_uart_rx #(
      .BIT_CYC(BIT_CYC)
   ) u_rx (
      .sys_clk_i(sys_clk_i),
      .srst_i(hold_rst),
      .rx_i(midi_s),
      .data_o(rx_byte),
      .valid_o(rx_valid)
   );

   // port mode, read buffer and its full flag
   logic uart_mode;
   mhp_byte_t rd_buf;
   logic rd_full;
   logic out_byte;
   mhp_byte_t out_buf;
   logic [7:0] run_cnt;
   always_ff @(posedge sys_clk_i) begin
      if (hold_rst) begin
         uart_mode <= 1'b0;
         rd_buf <= 8'h00;
         rd_full <= 1'b0;
         out_byte <= 1'b0;
         out_buf <= 8'h00;
         run_cnt <= 8'h00;
      end else begin
         if (run_cnt != 8'(RUN_DELAY)) run_cnt <= run_cnt + 8'h01;
         if (cmd_reset) uart_mode <= 1'b0;
         else if (cmd_uart) uart_mode <= 1'b1;
         // the synthesizer engine lies outside this block, so a written byte is only latched
         if (wr_data) begin
            out_buf <= data_s2;
            out_byte <= 1'b1;
         end else out_byte <= 1'b0;
         // bytes to host in uart mode; new byte wins over read clear
         if (uart_mode && rx_valid) begin
            rd_buf <= rx_byte;
            rd_full <= 1'b1;
         end else if (wr_ctrl) begin
            // commands are answered with an acknowledge byte
            rd_buf <= `MHP_ACK_BYTE;
            rd_full <= 1'b1;
         end else if (rd_data) rd_full <= 1'b0;
      end
   end

   // output-stage decode: status, bus drive and running indication
   wire mhp_byte_t status = status_byte(rd_full);
   wire rd_active = !cs_n_s && !rd_n_s;
   wire running = power_down_n_n_s && !hold_rst && run_cnt == 8'(RUN_DELAY);

   // outputs forced low in power-down, bus enable forced high; all outputs registered
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !power_down_n_n_s) begin
         host_data_bus_o <= 8'h00;
         host_data_bus_oe_n_o <= 1'b1;
         irq_o <= 1'b0;
         run_o <= 1'b0;
         buffered_crystal_clock_out_o <= 1'b0;
         clock_gen_enable_o <= 1'b0;
         synth_midi_o <= 1'b0;
      end else begin
         // drive only during a selected read
         host_data_bus_oe_n_o <= !rd_active;
         // the mux follows select live, so a status read needs no extra strobe
         host_data_bus_o <= sel_is_data(sel_s) ? rd_buf : status;
         irq_o <= rd_full && !(rd_data);
         run_o <= running;
         buffered_crystal_clock_out_o <= xtal_s2;
         clock_gen_enable_o <= 1'b1;
         // idle-high line to synth in uart mode, midi copy otherwise
         synth_midi_o <= uart_mode ? 1'b1 : midi_s;
      end
   end
endmodule

//--- dv/mhp_host_port_properties.sv
// pin-level assertions for the host port
`timescale 1ns/100ps
module mhp_host_port_properties (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic reset_n_i,
   input wire logic power_down_n_i,
   input wire logic chip_select_n_i,
   input wire logic read_n_i,
   input wire logic register_select_i,
   input wire logic crystal_clk_i,
   input wire mhp_pkg::mhp_byte_t host_data_bus_o,
   input wire logic host_data_bus_oe_n_o,
   input wire logic irq_o,
   input wire logic run_o,
   input wire logic buffered_crystal_clock_out_o,
   input wire logic clock_gen_enable_o,
   input wire logic synth_midi_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   // inputs pass two sync flops and one output flop, so waits are three or more
   a_power_down_n_all_low: assert property (!power_down_n_i [*4] |-> host_data_bus_oe_n_o &&
      {host_data_bus_o, irq_o, run_o, synth_midi_o, buffered_crystal_clock_out_o} == 12'h000) else $error("live");
   a_power_down_n_stops_clk: assert property ($fell(power_down_n_i) |-> ##[1:4] !clock_gen_enable_o)
      else $error("clock on");
   a_cs_idle_float: assert property (chip_select_n_i [*5] |-> host_data_bus_oe_n_o) else $error("drives");
   a_read_drives_bus: assert property ((!chip_select_n_i && !read_n_i && power_down_n_i) [*5]
      |-> !host_data_bus_oe_n_o) else $error("no drive");
   a_status_low_bits: assert property ((!chip_select_n_i && !read_n_i && register_select_i) [*5]
      |-> host_data_bus_o[6:0] == 7'h00) else $error("status");
   a_reset_run_low: assert property (!reset_n_i [*4] |-> !run_o) else $error("run in reset");
   a_buffered_crystal_clock_out_copy: assert property ((power_down_n_i && clock_gen_enable_o) [*4]
      |-> buffered_crystal_clock_out_o == $past(crystal_clk_i, 3)) else $error("buffered_crystal_clock_out");
   a_irq_read_clear: assert property ($rose(read_n_i) && !chip_select_n_i && !register_select_i && irq_o
      |-> ##[2:6] !irq_o) else $error("irq stuck");
endmodule
bind mhp_host_port mhp_host_port_properties chk (.*);

//--- dv/mhp_host_model.sv
// host processor model for the parallel bus
`timescale 1ns/100ps
module mhp_host_model (
   input wire logic sys_clk_i,
   input wire mhp_pkg::mhp_byte_t dev_data_i,
   input wire logic dev_oe_n_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic sel_o,
   output mhp_pkg::mhp_byte_t bus_o
);
   import mhp_pkg::*;
   mhp_byte_t drv_data = 8'h00;
   logic drv = 1'b0;
   // bus idles high on the strobes; undriven data shows the inverse of the last byte
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      sel_o = 1'b0;
   end
   assign bus_o = !dev_oe_n_i ? dev_data_i : (drv ? drv_data : ~drv_data);
   // strobes held five cycles low and eight high, sampled before release
   task automatic cycle(input logic wr, input logic cs_n, input logic sel, input mhp_byte_t d, output mhp_byte_t q);
      @(negedge sys_clk_i);
      cs_n_o = cs_n;
      sel_o = sel;
      drv_data = d;
      drv = wr;
      wr_n_o = !wr;
      rd_n_o = wr;
      repeat (5) @(negedge sys_clk_i);
      q = bus_o;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      cs_n_o = 1'b1;
      drv = 1'b0;
      repeat (4) @(negedge sys_clk_i);
   endtask
endmodule

//--- dv/midi_host_port_power_ctl_tb_top.sv
// testbench for the host port with uart pass-through and power-down
`timescale 1ns/100ps
`include "mhp_consts.svh"
module midi_host_port_power_ctl_tb_top;
   import mhp_pkg::*;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic reset_n_i = 1'b1;
   logic power_down_n_i = 1'b1;
   logic midi_in_i = 1'b1;
   logic crystal_clk_i = 1'b0;
   logic chip_select_n_i, read_n_i, write_n_i, register_select_i, host_data_bus_oe_n_o;
   logic irq_o, run_o, buffered_crystal_clock_out_o, clock_gen_enable_o, synth_midi_o;
   mhp_byte_t host_data_bus_i, host_data_bus_o, q, b;
   int bad_count = 0;
   int check_count = 0;
   int seed = 51;
   always #2 sys_clk_i = ~sys_clk_i;
   // crystal input wanders at random so the copy is really followed
   always @(negedge sys_clk_i) crystal_clk_i <= 1'($random(seed));
   mhp_host_port #(
      .BIT_CYC(8)
   ) uut (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .reset_n_i(reset_n_i),
      .power_down_n_i(power_down_n_i),
      .chip_select_n_i(chip_select_n_i),
      .read_n_i(read_n_i),
      .write_n_i(write_n_i),
      .register_select_i(register_select_i),
      .host_data_bus_i(host_data_bus_i),
      .host_data_bus_o(host_data_bus_o),
      .host_data_bus_oe_n_o(host_data_bus_oe_n_o),
      .midi_in_i(midi_in_i),
      .crystal_clk_i(crystal_clk_i),
      .irq_o(irq_o),
      .run_o(run_o),
      .buffered_crystal_clock_out_o(buffered_crystal_clock_out_o),
      .clock_gen_enable_o(clock_gen_enable_o),
      .synth_midi_o(synth_midi_o)
   );
   mhp_host_model host (.sys_clk_i(sys_clk_i), .dev_data_i(host_data_bus_o), .dev_oe_n_i(host_data_bus_oe_n_o),
      .cs_n_o(chip_select_n_i), .rd_n_o(read_n_i), .wr_n_o(write_n_i), .sel_o(register_select_i),
      .bus_o(host_data_bus_i));
   function automatic mhp_byte_t stat_exp(input logic has_byte);
      return mhp_byte_t'(!has_byte) << `MHP_STAT_IN_EMPTY;
   endfunction
   task automatic chk(input mhp_byte_t got, input mhp_byte_t exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pin_reset();
      reset_n_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk(8'(run_o), 8'h00);
      reset_n_i = 1'b1;
      repeat (30) @(negedge sys_clk_i);
   endtask
   // serial byte, lsb first, eight cycles a bit; routing sampled at the end of the start bit
   task automatic send(input mhp_byte_t v);
      for (int i = -1; i < 10; i++) begin
         if (i == 0) chk(8'(synth_midi_o), 8'h01);
         midi_in_i = (i < 0) ? 1'b0 : ((i > 7) ? 1'b1 : v[i]);
         repeat (8) @(negedge sys_clk_i);
      end
   endtask
   task automatic synth_chk();
      midi_in_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk(8'(synth_midi_o), 8'h00);
      midi_in_i = 1'b1;
      repeat (90) @(negedge sys_clk_i);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge sys_clk_i);
      srst_i = 1'b0;
      pin_reset();
      chk(8'(run_o), 8'h01);
      synth_chk();
      host.cycle(1'b0, 1'b1, 1'b0, 8'h5a, q);
      chk(q, 8'ha5);
      // a control write without chip select must not enter uart mode
      host.cycle(1'b1, 1'b1, 1'b1, `MHP_CMD_UART, q);
      chk(8'(irq_o), 8'h00);
      synth_chk();
      for (int k = 0; k < 4; k++) begin
         host.cycle(1'b1, 1'b0, 1'b1, `MHP_CMD_UART, q);
         chk(8'(irq_o), 8'h01);
         host.cycle(1'b0, 1'b0, 1'b0, 8'h00, q);
         chk(q, `MHP_ACK_BYTE);
         host.cycle(1'b0, 1'b0, 1'b1, 8'h00, q);
         chk(q, stat_exp(1'b0));
         b = (k == 3) ? 8'hff : ((k == 1) ? 8'h00 : 8'($random(seed)));
         send(b);
         host.cycle(1'b0, 1'b0, 1'b1, 8'h00, q);
         chk(q, stat_exp(1'b1));
         host.cycle(1'b0, 1'b0, 1'b0, 8'h00, q);
         chk(q, b);
         chk(8'(irq_o), 8'h00);
         if (k[0]) host.cycle(1'b1, 1'b0, 1'b1, `MHP_CMD_RESET, q);
         else pin_reset();
         synth_chk();
      end
      power_down_n_i = 1'b0;
      repeat (8) @(negedge sys_clk_i);
      chk(host_data_bus_o | {irq_o, run_o, buffered_crystal_clock_out_o, synth_midi_o, 4'h0}, 8'h00);
      chk(8'({host_data_bus_oe_n_o, clock_gen_enable_o}), 8'h02);
      power_down_n_i = 1'b1;
      pin_reset();
      chk(8'(run_o), 8'h01);
      results();
   end
   initial begin
      #60000;
      bad_count++;
      results();
   end
endmodule
